// ===== shared/stp_pkg.sv
// Package of constants and types for the spanning tree port state block
//
// Overview of operation
// - Each port holds exactly one of five states
// - Blocking port neither forwards nor accepts data
// - Listening keeps processing BPDUs, still passes no data
// - Learning inserts source addresses, forwards no data
// - Disabled answers management only, leaves via blocking
// - Reset puts every port in blocking
// - Blocking moves only to listening or disabled
// - Listening moves only to learning or disabled
// - Learning moves only to forwarding or disabled
// - Forwarding moves only to disabled
// - Disabled moves only to blocking
// - Non-BPDU frames dropped until port forwards
// - Enabled port walks blocking, listening, learning onward
// - Sent BPDU carries root id, cost, port id
// - BPDUs never relayed; own BPDU sent on change
// - Management may overwrite each port state
// - Lowest priority then lowest MAC wins root
// - Forward delay timer paces progress to forwarding
// - Forward delay default 15 s, range 4-30 s
// - Bridge id is 16-bit priority plus 48-bit MAC
// - Root sends hello BPDU every 2 s by default
package stp_pkg;

   // Port state encoding, three bits
   typedef enum logic [2:0] {
      ST_BLOCKING   = 3'h0,
      ST_LISTENING  = 3'h1,
      ST_LEARNING   = 3'h2,
      ST_FORWARDING = 3'h3,
      ST_DISABLED   = 3'h4
   } stp_state_e;

   // Widths of identifiers
   localparam int PRIO_W  = 16;
   localparam int MAC_W   = 48;
   localparam int BID_W   = PRIO_W + MAC_W;
   localparam int COST_W  = 32;
   localparam int PID_W   = 16;
   localparam int SEC_W   = 6;

   // Defaults
   localparam logic [PRIO_W-1:0] DEF_PRIO   = 16'h8000;
   localparam logic [SEC_W-1:0]  DEF_FWD_S  = 6'h0f;
   localparam logic [SEC_W-1:0]  MIN_FWD_S  = 6'h04;
   localparam logic [SEC_W-1:0]  MAX_FWD_S  = 6'h1e;
   localparam logic [SEC_W-1:0]  DEF_AGE_S  = 6'h14;
   localparam logic [SEC_W-1:0]  DEF_HELLO_S = 6'h02;
   localparam logic [SEC_W-1:0]  ONE_S      = 6'h01;
   localparam logic [SEC_W-1:0]  ZERO_S     = 6'h00;

   // Second tick: 1 s at 100 MHz
   localparam int CLK_HZ      = 100_000_000;
   localparam int TICK_S      = 1;
   localparam int SEC_CYCLES  = CLK_HZ * TICK_S;
   localparam int DIV_W       = 27;

endpackage : stp_pkg

// ===== src/stp_sec_timer.sv
// Down-counting seconds timer driven by a one-second enable
`timescale 1ns/100ps
module stp_sec_timer
   import stp_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset,
   // Control
   input  wire logic             load,       // Restart with load_val
   input  wire logic [SEC_W-1:0] load_val,
   input  wire logic             tick,       // One-second enable
   // Status
   output logic                  expired     // Count has reached zero
);

   logic [SEC_W-1:0] count;  // Seconds remaining

   wire  at_zero = (count == ZERO_S);

   assign expired = at_zero;

   // Load wins over counting so a restart is never lost
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count <= ZERO_S;
      end else if (load) begin
         count <= load_val;
      end else if (tick && !at_zero) begin
         count <= count - ONE_S;
      end
   end

endmodule : stp_sec_timer

// ===== src/stp_bid_cmp.sv
// Compares two bridge identifiers, lower wins
`timescale 1ns/100ps
module stp_bid_cmp
   import stp_pkg::*;
(
   // Operands: priority in the upper bits, MAC below
   input  wire logic [BID_W-1:0] bid_a,
   input  wire logic [BID_W-1:0] bid_b,
   // Result
   output logic                  a_better    // bid_a numerically lower
);

   // Priority sits on top, so plain compare favours lower priority first
   assign a_better = (bid_a < bid_b);

endmodule : stp_bid_cmp

// ===== src/stp_port_state.sv
// Per-port spanning tree state machine with frame gating and BPDU handling
`timescale 1ns/100ps
module stp_port_state
   import stp_pkg::*;
#(
   parameter int SEC_CYC = SEC_CYCLES  // Cycles per second, shorten for simulation
)(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Configuration
   input  wire logic              stp_enable,     // Spanning tree on for this port
   input  wire logic [PRIO_W-1:0] bridge_prio,    // Own bridge priority
   input  wire logic [MAC_W-1:0]  bridge_mac,     // Own MAC address
   input  wire logic [PID_W-1:0]  port_id,        // Own port identifier
   input  wire logic [COST_W-1:0] port_cost,      // Cost of this port's link
   input  wire logic [SEC_W-1:0]  fwd_delay_s,    // Forward delay, seconds
   input  wire logic [SEC_W-1:0]  max_age_s,      // Max age, seconds
   input  wire logic [SEC_W-1:0]  hello_s,        // Hello interval, seconds
   input  wire logic              port_is_root,   // Election says: root port
   input  wire logic              port_block,     // Election says: alternate, block
   // Management override
   input  wire logic              mgmt_wr,        // Pulse: force state
   input  wire logic [2:0]        mgmt_state,     // Requested state
   // Ingress frame qualifiers
   input  wire logic              rx_valid,       // Frame start on ingress
   input  wire logic              rx_is_bpdu,
   input  wire logic              rx_is_mgmt,
   input  wire logic [MAC_W-1:0]  rx_src_mac,
   input  wire logic [BID_W-1:0]  rx_root_id,     // Root id in received BPDU
   input  wire logic [COST_W-1:0] rx_root_cost,   // Cost in received BPDU
   // Egress frame qualifiers
   input  wire logic              tx_req,
   input  wire logic              tx_is_bpdu,
   input  wire logic              tx_is_mgmt,
   // Gating answers
   output logic                   rx_accept,      // Pass ingress frame on
   output logic                   tx_accept,      // Let egress frame out
   output logic                   rx_bpdu_consume,// BPDU kept, never relayed
   // Learning
   output logic                   learn_valid,
   output logic [MAC_W-1:0]       learn_mac,
   // BPDU generation
   output logic                   bpdu_tx_start,  // Pulse: send own BPDU
   output logic [BID_W-1:0]       bpdu_root_id,
   output logic [COST_W-1:0]      bpdu_root_cost,
   output logic [PID_W-1:0]       bpdu_port_id,
   // Status
   output logic [2:0]             port_state,
   output logic                   we_are_root
);

   stp_state_e state;          // Current state, 3-bit register
   stp_state_e next_state;

   logic [DIV_W-1:0]  div_cnt;       // One-second divider
   logic              sec_tick;
   logic              fwd_load;
   logic              fwd_done;
   logic              age_done;
   logic              hello_done;
   logic              hello_load;
   logic              bpdu_held;     // A stored BPDU is live
   logic [BID_W-1:0]  best_root;     // Best root id known
   logic [COST_W-1:0] best_cost;     // Our cost to that root
   logic              rx_better;
   logic              tx_pend;       // Own BPDU due, contents settle first

   // Own bridge id: priority above MAC
   wire [BID_W-1:0]  own_bid  = {bridge_prio, bridge_mac};

   // Clamp forward delay into the allowed range
   wire [SEC_W-1:0]  fwd_clamp = (fwd_delay_s < MIN_FWD_S) ? MIN_FWD_S :
                                 (fwd_delay_s > MAX_FWD_S) ? MAX_FWD_S : fwd_delay_s;

   // Frame kinds on this cycle
   wire rx_bpdu  = rx_valid && rx_is_bpdu;
   wire rx_data  = rx_valid && !rx_is_bpdu;
   wire in_fwd   = (state == ST_FORWARDING);
   wire in_learn = (state == ST_LEARNING);
   wire in_dis   = (state == ST_DISABLED);
   wire bpdu_ok  = !in_dis && stp_enable;   // Ports that process BPDUs

   // Legal target check for the management override
   wire [2:0] req = mgmt_state;
   wire legal_req =
      (state == ST_BLOCKING   && (req == ST_LISTENING || req == ST_DISABLED)) ||
      (state == ST_LISTENING  && (req == ST_LEARNING  || req == ST_DISABLED)) ||
      (state == ST_LEARNING   && (req == ST_FORWARDING|| req == ST_DISABLED)) ||
      (state == ST_FORWARDING && req == ST_DISABLED) ||
      (state == ST_DISABLED   && req == ST_BLOCKING);

   // A BPDU with a better root, or any BPDU under election block, sends a listening or learning port to disabled
   wire demote = rx_bpdu && bpdu_ok && (rx_better || port_block);

   // Seconds divider: one enable pulse per second, no second clock
   wire div_wrap = (div_cnt == DIV_W'(SEC_CYC - 1));

   // Restarted with the forward delay, so a paced state lasts whole seconds;
   // the age and hello timers may lose part of a second in trade
   always_ff @(posedge ref_clk) begin
      if (reset || div_wrap || fwd_load) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   assign sec_tick = div_wrap;

   // Next state: management first, then automatic progress
   always_comb begin
      next_state = state;
      fwd_load   = 1'b0;
      if (mgmt_wr) begin
         if (legal_req) begin
            next_state = stp_state_e'(req);
            fwd_load   = 1'b1;
         end                   // Illegal request: state unchanged
      end else if (!stp_enable) begin
         // Protocol off: a live port just forwards, disabled stays
         next_state = state;
      end else begin
         unique case (state)
            ST_BLOCKING: begin
               // Leave blocking only when election allows
               if (!port_block) begin
                  next_state = ST_LISTENING;
                  fwd_load   = 1'b1;
               end
            end
            ST_LISTENING: begin
               if (demote) begin
                  next_state = ST_DISABLED;   // Blocking is not a legal target here
               end else if (fwd_done) begin
                  next_state = ST_LEARNING;
                  fwd_load   = 1'b1;
               end
            end
            ST_LEARNING: begin
               if (demote) begin
                  next_state = ST_DISABLED;
               end else if (fwd_done) begin
                  next_state = ST_FORWARDING;
               end
            end
            ST_FORWARDING: begin
               if (port_block) begin
                  next_state = ST_DISABLED;
               end
            end
            ST_DISABLED: begin
               // Re-entry always passes through blocking
               next_state = ST_BLOCKING;
            end
            default: begin
               next_state = ST_BLOCKING;
            end
         endcase
      end
   end

   // State register, blocking out of reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= ST_BLOCKING;
      end else begin
         state <= next_state;
      end
   end

   assign port_state = state;

   // Forward delay timer restarts on each entry to listening or learning
   stp_sec_timer u_fwd (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .load     (fwd_load),
      .load_val (fwd_clamp),
      .tick     (sec_tick),
      .expired  (fwd_done)
   );

   // Root comparison of received against stored best
   stp_bid_cmp u_cmp (
      .bid_a    (rx_root_id),
      .bid_b    (best_root),
      .a_better (rx_better)
   );

   // Max age timer: reloaded by every processed BPDU
   stp_sec_timer u_age (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .load     (rx_bpdu && bpdu_ok),
      .load_val (max_age_s),
      .tick     (sec_tick),
      .expired  (age_done)
   );

   // Stored root information; stale info is dropped and we claim root
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bpdu_held <= 1'b0;
         best_root <= '1;
         best_cost <= '0;
      end else if (rx_bpdu && bpdu_ok && (rx_better || !bpdu_held)) begin
         bpdu_held <= 1'b1;
         best_root <= rx_root_id;
         best_cost <= rx_root_cost + port_cost;
      end else if (bpdu_held && age_done) begin
         bpdu_held <= 1'b0;
         best_root <= '1;
         best_cost <= '0;
      end
   end

   // Own id wins unless a better root is stored
   wire own_better;
   stp_bid_cmp u_own (
      .bid_a    (own_bid),
      .bid_b    (best_root),
      .a_better (own_better)
   );

   assign we_are_root = !bpdu_held || own_better || (own_bid == best_root);

   // Hello timer paces periodic BPDUs while root
   stp_sec_timer u_hello (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .load     (hello_load),
      .load_val (hello_s),
      .tick     (sec_tick),
      .expired  (hello_done)
   );

   // Topology change: a new best root was adopted or aged out
   wire topo_change = (rx_bpdu && bpdu_ok && rx_better) || (bpdu_held && age_done);
   wire hello_fire  = we_are_root && hello_done && bpdu_ok;
   assign hello_load = hello_fire || reset;

   // Own BPDU contents and start pulse; the pulse waits one cycle so that
   // it goes out beside contents already built from the adopted root
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_pend        <= 1'b0;
         bpdu_tx_start  <= 1'b0;
         bpdu_root_id   <= '0;
         bpdu_root_cost <= '0;
         bpdu_port_id   <= '0;
      end else begin
         tx_pend        <= (topo_change || hello_fire) && bpdu_ok;
         bpdu_tx_start  <= tx_pend;
         bpdu_root_id   <= we_are_root ? own_bid : best_root;
         bpdu_root_cost <= we_are_root ? '0 : best_cost;
         bpdu_port_id   <= port_id;
      end
   end

   // Ingress gating: data only when forwarding, or every non-BPDU frame if protocol off and not disabled
   assign rx_accept = rx_valid && !rx_is_bpdu &&
                      ((stp_enable && in_fwd) ||
                       (!stp_enable && !in_dis) ||
                       (in_dis && rx_is_mgmt));
   // Received BPDUs are always consumed, never relayed
   assign rx_bpdu_consume = rx_bpdu;
   // Egress gating: own BPDUs pass unless disabled
   assign tx_accept = tx_req &&
                      ((tx_is_bpdu && !in_dis) ||
                       (in_dis && tx_is_mgmt) ||
                       (!tx_is_bpdu && stp_enable && in_fwd) ||
                       (!tx_is_bpdu && !stp_enable && !in_dis));

   // Learning of source addresses in learning and forwarding
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         learn_valid <= 1'b0;
         learn_mac   <= '0;
      end else begin
         learn_valid <= rx_data && (in_learn || in_fwd || (!stp_enable && !in_dis));
         learn_mac   <= rx_src_mac;
      end
   end

endmodule : stp_port_state

// ===== verification/stp_port_state_asserts.sv
// Concurrent checks on the ports of the spanning tree port state block
`timescale 1ns/100ps
module stp_port_state_chk
   import stp_pkg::*;
(
   // Clock and reset
   input wire logic             ref_clk,
   input wire logic             reset,
   // Inputs watched
   input wire logic             stp_enable,
   input wire logic             mgmt_wr,
   input wire logic [2:0]       mgmt_state,
   input wire logic             rx_valid,
   input wire logic             rx_is_bpdu,
   input wire logic             rx_is_mgmt,
   input wire logic [MAC_W-1:0] rx_src_mac,
   input wire logic             tx_req,
   input wire logic             tx_is_bpdu,
   input wire logic             tx_is_mgmt,
   input wire logic [PID_W-1:0] port_id,
   // Outputs checked
   input wire logic             rx_accept,
   input wire logic             tx_accept,
   input wire logic             rx_bpdu_consume,
   input wire logic             learn_valid,
   input wire logic [MAC_W-1:0] learn_mac,
   input wire logic             bpdu_tx_start,
   input wire logic [PID_W-1:0] bpdu_port_id,
   input wire logic [2:0]       port_state
);
   // One domain: core clock, quiet in reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Plain data frames, neither BPDU nor management
   wire rx_data = rx_valid && !rx_is_bpdu && !rx_is_mgmt;
   wire tx_data = tx_req && !tx_is_bpdu && !tx_is_mgmt;
   // Low on the first edge after reset, where $past still sees the old state
   logic run;
   always_ff @(posedge ref_clk) run <= !reset;

   AST_STATE_RANGE:
      assert property (port_state <= 3'h4) else $error("Port state outside the five states");
   AST_RESET_BLOCKING:
      assert property ($past(reset) |-> port_state == ST_BLOCKING) else $error("Not blocking after reset");
   AST_FROM_BLOCKING:
      assert property (run && $past(port_state) == ST_BLOCKING |->
         port_state inside {ST_BLOCKING, ST_LISTENING, ST_DISABLED}) else $error("Bad move from blocking");
   AST_FROM_LISTENING:
      assert property (run && $past(port_state) == ST_LISTENING |->
         port_state inside {ST_LISTENING, ST_LEARNING, ST_DISABLED}) else $error("Bad move from listening");
   AST_FROM_LEARNING:
      assert property (run && $past(port_state) == ST_LEARNING |->
         port_state inside {ST_LEARNING, ST_FORWARDING, ST_DISABLED}) else $error("Bad move from learning");
   AST_FROM_FORWARDING:
      assert property (run && $past(port_state) == ST_FORWARDING |->
         port_state inside {ST_FORWARDING, ST_DISABLED}) else $error("Bad move from forwarding");
   AST_FROM_DISABLED:
      assert property (run && $past(port_state) == ST_DISABLED |->
         port_state inside {ST_DISABLED, ST_BLOCKING}) else $error("Bad move from disabled");
   AST_RX_GATE:
      assert property (stp_enable && rx_data && port_state != ST_FORWARDING |-> !rx_accept)
         else $error("Ingress data passed before forwarding");
   AST_TX_GATE:
      assert property (stp_enable && tx_data && port_state != ST_FORWARDING |-> !tx_accept)
         else $error("Egress data passed before forwarding");
   AST_BPDU_KEPT:
      assert property (stp_enable && rx_valid && rx_is_bpdu && port_state != ST_DISABLED |->
         rx_bpdu_consume && !rx_accept) else $error("BPDU relayed instead of consumed");
   AST_DISABLED_MGMT_ONLY:
      assert property (port_state == ST_DISABLED && rx_valid |-> rx_accept == rx_is_mgmt)
         else $error("Disabled port answered non-management frame");
   AST_LEARN:
      assert property (port_state == ST_LEARNING && rx_data |=> learn_valid && learn_mac == $past(rx_src_mac))
         else $error("Source address not learned");
   AST_BAD_CODE:
      assert property (!stp_enable && mgmt_wr && mgmt_state > 3'h4 |=> $stable(port_state))
         else $error("Undefined state code accepted");
   AST_BPDU_PORT_ID:
      assert property (bpdu_tx_start |-> bpdu_port_id == port_id) else $error("BPDU port id wrong");
endmodule : stp_port_state_chk

bind stp_port_state stp_port_state_chk stp_port_state_chk_i (
   .ref_clk, .reset, .stp_enable, .mgmt_wr, .mgmt_state, .rx_valid, .rx_is_bpdu, .rx_is_mgmt,
   .rx_src_mac, .tx_req, .tx_is_bpdu, .tx_is_mgmt, .port_id, .rx_accept, .tx_accept,
   .rx_bpdu_consume, .learn_valid, .learn_mac, .bpdu_tx_start, .bpdu_port_id, .port_state);

// ===== verification/stp_nbr.sv
// Neighbour bridge model presenting frames on the ingress side
`timescale 1ns/100ps
module stp_nbr
   import stp_pkg::*;
(
   // Clock
   input  wire logic              ref_clk,
   // Control from the bench
   input  wire logic              go,      // Present one frame next cycle
   input  wire logic [1:0]        kind,    // 0 data, 1 BPDU, 2 management
   input  wire logic              better,  // BPDU claims a lower root
   // Ingress qualifiers
   output logic                   rx_valid,
   output logic                   rx_is_bpdu,
   output logic                   rx_is_mgmt,
   output logic [MAC_W-1:0]       rx_src_mac,
   output logic [BID_W-1:0]       rx_root_id,
   output logic [COST_W-1:0]      rx_root_cost
);
   initial {rx_valid, rx_is_bpdu, rx_is_mgmt, rx_src_mac, rx_root_id, rx_root_cost} = '0;
   // Frame lasts one cycle; fields flip between frames so stale values never hold steady
   always @(posedge ref_clk) begin
      rx_valid     <= go;
      rx_is_bpdu   <= go && kind == 2'h1;
      rx_is_mgmt   <= go && kind == 2'h2;
      rx_src_mac   <= go ? 48'h0200_0000_0b0b : ~rx_src_mac;
      rx_root_id   <= !go ? ~rx_root_id : better ? 64'h0000_0000_0000_0001 : 64'hffff_ffff_ffff_ffff;
      rx_root_cost <= go ? 32'h0000_0010 : ~rx_root_cost;
   end
endmodule : stp_nbr

// ===== verification/tb.sv
// Self-checking bench for the spanning tree port state block
`timescale 1ns/100ps
module tb
   import stp_pkg::*;
;
   localparam int SEC   = 10;    // Shortened second, in cycles
   localparam int LIMIT = 3000;  // Cycle ceiling of the run
   // Table row: state, election block, frame kind, expected ingress and egress answers
   typedef struct packed {
      logic [2:0] st;
      logic       blk;
      logic [1:0] kind;
      logic       ea;
      logic       et;
   } stp_row_s;
   localparam stp_row_s ROWS [8] = '{
      '{ST_BLOCKING, 1'h1, 2'h0, 1'h0, 1'h0}, '{ST_BLOCKING, 1'h1, 2'h1, 1'h0, 1'h1},
      '{ST_LISTENING, 1'h0, 2'h0, 1'h0, 1'h0}, '{ST_LISTENING, 1'h0, 2'h1, 1'h0, 1'h1},
      '{ST_LEARNING, 1'h0, 2'h0, 1'h0, 1'h0}, '{ST_LEARNING, 1'h0, 2'h1, 1'h0, 1'h1},
      '{ST_FORWARDING, 1'h0, 2'h0, 1'h1, 1'h1}, '{ST_FORWARDING, 1'h0, 2'h2, 1'h1, 1'h1}};
   // Stimulus, all given at time zero
   logic ref_clk = 1'h0, reset = 1'h1, stp_enable = 1'h1, port_block = 1'h1, mgmt_wr = 1'h0;
   logic go = 1'h0, better = 1'h0, tx_req = 1'h0, tx_is_bpdu = 1'h0, tx_is_mgmt = 1'h0;
   logic [1:0]        kind = 2'h0;
   logic [2:0]        mgmt_state = 3'h0;
   logic [SEC_W-1:0]  fwd_s = 6'h04;
   logic [PRIO_W-1:0] bridge_prio = DEF_PRIO;
   logic [MAC_W-1:0]  bridge_mac = 48'h0200_0000_00aa;
   // Observed
   logic rx_valid, rx_is_bpdu, rx_is_mgmt, rx_accept, tx_accept, rx_bpdu_consume, learn_valid, bpdu_tx_start;
   logic [MAC_W-1:0]  rx_src_mac, learn_mac;
   logic [BID_W-1:0]  rx_root_id;
   logic [COST_W-1:0] rx_root_cost;
   logic [2:0]        port_state;
   logic [BID_W-1:0]  bpdu_root_id;
   logic [COST_W-1:0] bpdu_root_cost;
   logic [PID_W-1:0]  bpdu_port_id;
   logic              we_are_root;
   int fails = 0, checked = 0, cycles = 0;

   stp_port_state #(.SEC_CYC(SEC)) stp_port_state_i (
      .ref_clk, .reset, .stp_enable, .bridge_prio, .bridge_mac, .port_id(16'h0007),
      .port_cost(32'h0000_0004), .fwd_delay_s(fwd_s), .max_age_s(DEF_AGE_S), .hello_s(DEF_HELLO_S),
      .port_is_root(1'h0), .port_block, .mgmt_wr, .mgmt_state, .rx_valid, .rx_is_bpdu, .rx_is_mgmt,
      .rx_src_mac, .rx_root_id, .rx_root_cost, .tx_req, .tx_is_bpdu, .tx_is_mgmt, .rx_accept, .tx_accept,
      .rx_bpdu_consume, .learn_valid, .learn_mac, .bpdu_tx_start, .bpdu_root_id, .bpdu_root_cost,
      .bpdu_port_id, .port_state, .we_are_root);
   stp_nbr stp_nbr_i (.ref_clk, .go, .kind, .better, .rx_valid, .rx_is_bpdu, .rx_is_mgmt,
      .rx_src_mac, .rx_root_id, .rx_root_cost);

   initial forever #5 ref_clk = ~ref_clk;
   // Ceiling so a stuck wait cannot hang the run
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check(input logic [BID_W-1:0] seen, input logic [BID_W-1:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // Bounded wait for a state, sampled on the falling edge
   task automatic wait_st(input logic [2:0] st);
      for (int i = 0; i < 300 && port_state !== st; i++)
         @(negedge ref_clk);
   endtask : wait_st
   // One frame each way of the given kind, answers sampled mid-frame
   task automatic frame(input logic [1:0] k, input logic b, input logic ea, input logic et);
      @(posedge ref_clk);
      go <= 1'h1;
      kind <= k;
      better <= b;
      @(posedge ref_clk);
      go <= 1'h0;
      tx_req <= 1'h1;
      tx_is_bpdu <= k == 2'h1;
      tx_is_mgmt <= k == 2'h2;
      @(negedge ref_clk);
      check(3'(rx_accept), 3'(ea), "ingress answer");
      check(3'(tx_accept), 3'(et), "egress answer");
      check(3'(rx_bpdu_consume), 3'(k == 2'h1), "BPDU consumed");
      @(posedge ref_clk);
      tx_req <= 1'h0;
   endtask : frame
   // Management write, then the state it should leave
   task automatic mgmt(input logic [2:0] s, input logic [2:0] exp);
      @(posedge ref_clk);
      mgmt_wr <= 1'h1;
      mgmt_state <= s;
      @(posedge ref_clk);
      mgmt_wr <= 1'h0;
      @(negedge ref_clk);
      check(port_state, exp, "forced state");
   endtask : mgmt
   // Time spent in a paced state; the forward delay is clamped to four seconds here
   task automatic dwell(input logic [2:0] st);
      int n;
      n = 0;
      wait_st(st);
      while (port_state === st && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      check(3'(n >= SEC * 4 - 1 && n <= SEC * 5), 3'h1, "dwell time");
      check(port_state, st + 3'h1, "next state");
   endtask : dwell
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'h0;
      @(negedge ref_clk);
      check(port_state, ST_BLOCKING, "state after reset");
      // Walk the states, held in blocking by the election at first
      foreach (ROWS[i]) begin
         @(posedge ref_clk);
         port_block <= ROWS[i].blk;
         wait_st(ROWS[i].st);
         check(port_state, ROWS[i].st, "walk state");
         frame(ROWS[i].kind, 1'h0, ROWS[i].ea, ROWS[i].et);
      end
      $display("Gating table done");
      mgmt(ST_BLOCKING, ST_FORWARDING);
      mgmt(ST_DISABLED, ST_DISABLED);
      @(negedge ref_clk);
      check(port_state, ST_BLOCKING, "leave disabled");
      check(bpdu_root_id, {DEF_PRIO, bridge_mac}, "own root id");
      check(64'(bpdu_root_cost), 64'h0, "own root cost");
      check(64'(we_are_root), 64'h1, "root claimed");
      $display("Forced moves done");
      @(posedge ref_clk);
      stp_enable <= 1'h0;
      mgmt(ST_DISABLED, ST_DISABLED);
      frame(2'h0, 1'h0, 1'h0, 1'h0);
      frame(2'h2, 1'h0, 1'h1, 1'h1);
      mgmt(3'h6, ST_DISABLED);
      mgmt(ST_FORWARDING, ST_DISABLED);
      mgmt(ST_BLOCKING, ST_BLOCKING);
      mgmt(ST_FORWARDING, ST_BLOCKING);
      frame(2'h0, 1'h0, 1'h1, 1'h1);
      $display("Spanning tree off done");
      @(posedge ref_clk);
      stp_enable <= 1'h1;
      fwd_s <= 6'h02;
      wait_st(ST_LISTENING);
      frame(2'h1, 1'h1, 1'h0, 1'h1);
      wait_st(ST_BLOCKING);
      check(port_state, ST_BLOCKING, "demoted by better BPDU");
      check(bpdu_root_id, 64'h0000_0000_0000_0001, "BPDU root id");
      check(64'(bpdu_root_cost), 64'h0000_0000_0000_0014, "BPDU root cost");
      check(64'(bpdu_port_id), 64'h0000_0000_0000_0007, "BPDU port id");
      check(64'(we_are_root), 64'h0, "root given up");
      dwell(ST_LISTENING);
      dwell(ST_LEARNING);
      $display("Timing done");
      @(posedge ref_clk);
      reset <= 1'h1;
      @(posedge ref_clk);
      reset <= 1'h0;
      @(negedge ref_clk);
      check(port_state, ST_BLOCKING, "state after second reset");
      $display("Reset done");
      end_of_test();
   end
endmodule : tb
